//--- logic/swc_consts.svh
// constants of the sleep and wake-up controller
`ifndef SWC_CONSTS_SVH
`define SWC_CONSTS_SVH
// ****************************************************************
// register map
// ****************************************************************
`define SWC_ADDR_W 4
`define SWC_REG_CTRL 4'h0
`define SWC_REG_STATUS 4'h1
`define SWC_REG_IRQ_EN 4'h2
`define SWC_REG_CAUSE 4'h3
`define SWC_REG_WDT_LIMIT 4'h4
// ctrl fields
`define SWC_CTRL_WDT_EN 0
`define SWC_CTRL_GIE 1
`define SWC_CTRL_OSC_LSB 2
`define SWC_CTRL_RESET 32'h0000_0001
// status fields
`define SWC_STAT_PD 0
`define SWC_STAT_TO 1
`define SWC_STAT_ASLEEP 2
`define SWC_STAT_STARTUP 3
// irq enable fields
`define SWC_IEN_EXT 0
`define SWC_IEN_PORT 1
`define SWC_IEN_CMP 2
`define SWC_IEN_RESET 32'h0000_0000
// ****************************************************************
// timing
// ****************************************************************
`define SWC_OST_PERIODS 1024
`define SWC_OSC_PER_CLK 1
`define SWC_OST_CYCLES (`SWC_OST_PERIODS / `SWC_OSC_PER_CLK)
`define SWC_WDT_LIMIT_RESET 32'h0000_ffff
`define SWC_IRQ_VECTOR 13'h0004
`endif

//--- logic/swc_pkg.sv
// types of the sleep and wake-up controller
`include "swc_consts.svh"
package swc_pkg;
  typedef enum logic [1:0] {
    osc_rc,
    crystal_osc_mode,
    high_speed_osc_mode,
    low_power_osc_mode
  } swc_osc_e;
  typedef enum logic [1:0] {
    wake_none,
    wake_watchdog,
    wake_interrupt,
    wake_master_clear
  } swc_cause_e;
  typedef logic [`SWC_ADDR_W-1:0] swc_addr_t;
endpackage : swc_pkg

//--- logic/swc_top.sv
// sleep and wake-up controller with avalon register slave
`include "swc_consts.svh"
module swc_top #(
  parameter int OST_CYCLES = `SWC_OST_CYCLES,
  parameter int PIN_W = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // avalon slave
  input wire swc_pkg::swc_addr_t avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // core handshake
  input wire logic sleep_exec,
  input wire logic [12:0] pc_now,
  output logic [12:0] prefetch_addr,
  output logic core_run,
  output logic core_reset,
  output logic branch_vector,
  output logic [12:0] vector_addr,
  // wake sources
  input wire logic master_clear_pin_n,
  input wire logic external_int_pin,
  input wire logic port_change_flag,
  input wire logic comparator_flag,
  input wire logic wdt_osc_tick,
  // oscillator
  output logic osc_driver_en,
  // io hold
  input wire logic [PIN_W-1:0] pin_out_core,
  input wire logic [PIN_W-1:0] pin_oe_core,
  output logic [PIN_W-1:0] pin_out,
  output logic [PIN_W-1:0] pin_oe,
  // watchdog reset to the core, internal only
  output logic wdt_reset
);
  import swc_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum logic [1:0] {
    st_run,
    st_sleep,
    st_startup,
    st_resume
  } swc_state_e;

  typedef struct packed {
    swc_state_e st;
    logic [1:0] master_clear_pin_sync;
    logic [1:0] ext_sync;
    logic [1:0] port_sync;
    logic [1:0] cmp_sync;
    logic ext_prev;
    logic ext_flag;
    logic wdt_en;
    logic global_irq_enable;
    swc_osc_e osc;
    logic [2:0] irq_en;
    logic [2:0] irq_en_at_sleep;
    logic pd;
    logic to;
    swc_cause_e cause;
    logic [31:0] wdt_limit;
    logic [15:0] ost_cnt;
    logic [12:0] prefetch;
    logic core_run;
    logic core_reset;
    logic branch;
    logic osc_en;
    logic [PIN_W-1:0] pin_out;
    logic [PIN_W-1:0] pin_oe;
    logic wdt_reset;
    logic wdt_clear;
    logic [31:0] rdata;
    logic ack;
  } swc_top_s;

  swc_top_s state_ff;
  swc_top_s nxt_state;
  logic wdt_timeout;

  initial begin
    if (OST_CYCLES < 1 || OST_CYCLES > 65535) begin
      $error("swc_top startup count out of range");
    end
    if (PIN_W < 1) begin
      $error("swc_top pin width too small");
    end
  end

  function automatic logic [2:0] pending(input logic [2:0] en, input logic [2:0] flg);
    pending = en & flg;
  endfunction : pending

  // ****************************************************************
  // watchdog
  // ****************************************************************
  swc_wdt #(
    .WIDTH(32)
  ) u_wdt (
    .core_clk(core_clk),
    .rst(rst),
    .enable(state_ff.wdt_en),
    .tick(wdt_osc_tick),
    .clear(state_ff.wdt_clear),
    .limit(state_ff.wdt_limit),
    .timeout(wdt_timeout)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [2:0] flags;
    logic master_clear_pin_active;
    logic bus_req;
    flags = '0;
    master_clear_pin_active = 1'b0;
    bus_req = 1'b0;
    nxt_state = state_ff;
    nxt_state.master_clear_pin_sync = {state_ff.master_clear_pin_sync[0], ~master_clear_pin_n};
    nxt_state.ext_sync = {state_ff.ext_sync[0], external_int_pin};
    nxt_state.port_sync = {state_ff.port_sync[0], port_change_flag};
    nxt_state.cmp_sync = {state_ff.cmp_sync[0], comparator_flag};
    nxt_state.ext_prev = state_ff.ext_sync[1];
    nxt_state.wdt_clear = 1'b0;
    nxt_state.wdt_reset = 1'b0;
    nxt_state.core_reset = 1'b0;
    nxt_state.branch = 1'b0;
    nxt_state.ack = 1'b0;
    master_clear_pin_active = state_ff.master_clear_pin_sync[1];
    // rising edge on the external pin sets its flag
    if (state_ff.ext_sync[1] && !state_ff.ext_prev) begin
      nxt_state.ext_flag = 1'b1;
    end
    flags = {state_ff.cmp_sync[1], state_ff.port_sync[1], state_ff.ext_flag};

    // avalon slave, one wait cycle then answer
    bus_req = (avs_read || avs_write) && !state_ff.ack;
    if (bus_req) begin
      nxt_state.ack = 1'b1;
      nxt_state.rdata = '0;
      if (avs_address == `SWC_REG_CTRL) begin
        nxt_state.rdata = {28'h0, state_ff.osc, state_ff.global_irq_enable, state_ff.wdt_en};
      end else if (avs_address == `SWC_REG_STATUS) begin
        nxt_state.rdata = {28'h0, state_ff.st == st_startup, state_ff.st == st_sleep,
                           state_ff.to, state_ff.pd};
      end else if (avs_address == `SWC_REG_IRQ_EN) begin
        nxt_state.rdata = {28'h0, state_ff.ext_flag, state_ff.irq_en};
      end else if (avs_address == `SWC_REG_CAUSE) begin
        nxt_state.rdata = {30'h0, state_ff.cause};
      end else if (avs_address == `SWC_REG_WDT_LIMIT) begin
        nxt_state.rdata = state_ff.wdt_limit;
      end
    end
    // writes land at the edge where waitrequest is seen low
    if (state_ff.ack && avs_write) begin
      if (avs_address == `SWC_REG_CTRL) begin
        nxt_state.wdt_en = avs_writedata[`SWC_CTRL_WDT_EN];
        nxt_state.global_irq_enable = avs_writedata[`SWC_CTRL_GIE];
        nxt_state.osc = swc_osc_e'(avs_writedata[`SWC_CTRL_OSC_LSB +: 2]);
      end else if (avs_address == `SWC_REG_IRQ_EN) begin
        nxt_state.irq_en = avs_writedata[2:0];
        // writing one to bit 3 clears the external flag; a new edge wins
        if (avs_writedata[3] && !(state_ff.ext_sync[1] && !state_ff.ext_prev)) begin
          nxt_state.ext_flag = 1'b0;
        end
      end else if (avs_address == `SWC_REG_WDT_LIMIT) begin
        nxt_state.wdt_limit = avs_writedata;
      end
    end

    case (state_ff.st)
      st_run: begin
        nxt_state.pin_out = pin_out_core;
        nxt_state.pin_oe = pin_oe_core;
        if (wdt_timeout) begin
          nxt_state.wdt_reset = 1'b1;
          nxt_state.core_reset = 1'b1;
          nxt_state.to = 1'b0;
        end else if (sleep_exec) begin
          nxt_state.st = st_sleep;
          nxt_state.wdt_clear = 1'b1;
          nxt_state.pd = 1'b0;
          nxt_state.to = 1'b1;
          nxt_state.prefetch = pc_now + 13'h0001;
          nxt_state.irq_en_at_sleep = state_ff.irq_en;
          nxt_state.core_run = 1'b0;
          nxt_state.osc_en = 1'b0;
          nxt_state.cause = wake_none;
        end
      end
      st_sleep: begin
        // pins keep their last driven state
        if (wdt_timeout) begin
          nxt_state.to = 1'b0;
          nxt_state.cause = wake_watchdog;
          nxt_state.wdt_clear = 1'b1;
          nxt_state.osc_en = 1'b1;
          nxt_state.ost_cnt = '0;
          nxt_state.st = (state_ff.osc == osc_rc) ? st_resume : st_startup;
        end else if (|pending(state_ff.irq_en_at_sleep, flags)) begin
          nxt_state.cause = wake_interrupt;
          nxt_state.wdt_clear = 1'b1;
          nxt_state.osc_en = 1'b1;
          nxt_state.ost_cnt = '0;
          nxt_state.st = (state_ff.osc == osc_rc) ? st_resume : st_startup;
        end
      end
      st_startup: begin
        if (state_ff.ost_cnt == 16'(OST_CYCLES - 1)) begin
          nxt_state.st = st_resume;
        end else begin
          nxt_state.ost_cnt = state_ff.ost_cnt + 16'h0001;
        end
      end
      st_resume: begin
        nxt_state.core_run = 1'b1;
        nxt_state.st = st_run;
        // interrupt wake with gie set branches in the same cycle the core restarts
        nxt_state.branch = (state_ff.cause == wake_interrupt) && state_ff.global_irq_enable;
      end
      default: begin
        nxt_state.st = st_run;
      end
    endcase

    // master clear overrides the state machine, resets the core and clears gie
    if (master_clear_pin_active) begin
      nxt_state.st = st_run;
      nxt_state.core_reset = 1'b1;
      nxt_state.core_run = 1'b1;
      nxt_state.osc_en = 1'b1;
      nxt_state.wdt_clear = 1'b1;
      nxt_state.global_irq_enable = 1'b0;
      if (state_ff.st != st_run) begin
        nxt_state.cause = wake_master_clear;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff <= '0;
      state_ff.st <= st_run;
      state_ff.pd <= 1'b1;
      state_ff.to <= 1'b1;
      state_ff.wdt_en <= 1'(`SWC_CTRL_RESET);
      state_ff.global_irq_enable <= 1'b0;
      state_ff.osc <= osc_rc;
      state_ff.irq_en <= 3'(`SWC_IEN_RESET);
      state_ff.wdt_limit <= `SWC_WDT_LIMIT_RESET;
      state_ff.core_run <= 1'b1;
      state_ff.osc_en <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign avs_readdata = state_ff.rdata;
  assign avs_waitrequest = ~state_ff.ack;
  assign prefetch_addr = state_ff.prefetch;
  assign core_run = state_ff.core_run;
  assign core_reset = state_ff.core_reset;
  assign branch_vector = state_ff.branch;
  assign vector_addr = `SWC_IRQ_VECTOR;
  assign osc_driver_en = state_ff.osc_en;
  assign pin_out = state_ff.pin_out;
  assign pin_oe = state_ff.pin_oe;
  assign wdt_reset = state_ff.wdt_reset;
endmodule : swc_top

//--- logic/swc_wdt.sv
// watchdog counter running on its own oscillator tick
module swc_wdt #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // control
  input wire logic enable,
  input wire logic tick,
  input wire logic clear,
  input wire logic [WIDTH-1:0] limit,
  // result
  output logic timeout
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic timeout;
  } swc_wdt_s;
  swc_wdt_s state_ff;
  swc_wdt_s nxt_state;

  initial begin
    if (WIDTH < 2) begin
      $error("swc_wdt width too small");
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_state.timeout = 1'b0;
    if (clear || !enable) begin
      nxt_state.count = '0;
    end else if (tick) begin
      if (state_ff.count >= limit) begin
        nxt_state.count = '0;
        nxt_state.timeout = 1'b1;
      end else begin
        nxt_state.count = state_ff.count + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign timeout = state_ff.timeout;
endmodule : swc_wdt

//--- tb/swc_core_model.sv
// behavioural core and watchdog oscillator at the far side
module swc_core_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // bench command and controller state
  input wire logic go_sleep,
  input wire logic core_run,
  // core and watchdog oscillator outputs
  output logic sleep_exec = 1'b0,
  output logic [12:0] pc_now = 13'h0,
  output logic [7:0] pin_out_core = 8'h0,
  output logic [7:0] pin_oe_core = 8'h0,
  output logic wdt_osc_tick = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge core_clk) begin
    wdt_osc_tick <= !wdt_osc_tick && !rst;
    sleep_exec <= go_sleep && core_run && !sleep_exec && !rst;
    if (core_run === 1'b1) begin
      pc_now <= pc_now + 13'h1;
      pin_out_core <= pin_out_core + 8'h1;
      pin_oe_core <= ~pin_oe_core;
    end
  end
endmodule : swc_core_model

//--- tb/swc_monitor.sv
// assertions on the ports of the sleep and wake-up controller
module swc_monitor #(
  parameter int OST_CYCLES = 16,
  parameter int PIN_W = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // observed ports
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic sleep_exec,
  input wire logic [12:0] pc_now,
  input wire logic [12:0] prefetch_addr,
  input wire logic core_run,
  input wire logic branch_vector,
  input wire logic [12:0] vector_addr,
  input wire logic osc_driver_en,
  input wire logic [PIN_W-1:0] pin_out,
  input wire logic [PIN_W-1:0] pin_oe,
  input wire logic wdt_reset
);
  logic [15:0] ost_cnt_ff;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ****************************************************************
  // startup length counter
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (rst || core_run || !osc_driver_en) begin
      ost_cnt_ff <= 16'h0;
    end else begin
      ost_cnt_ff <= ost_cnt_ff + 16'h1;
    end
  end
  chk_sleep_stop: assert property (sleep_exec && core_run |=> !core_run && !osc_driver_en)
    else $error("core kept running after sleep");
  chk_prefetch_next: assert property (sleep_exec && core_run |=> prefetch_addr == $past(pc_now) + 13'h1)
    else $error("prefetch address wrong");
  chk_vector_addr: assert property (vector_addr == 13'h0004)
    else $error("vector address wrong");
  chk_pins_frozen: assert property (!core_run && $past(!core_run) |-> $stable(pin_out) && $stable(pin_oe))
    else $error("pins moved during sleep");
  chk_osc_with_run: assert property (core_run |-> osc_driver_en)
    else $error("core runs without oscillator");
  chk_sleep_no_reset: assert property (!core_run |-> !wdt_reset)
    else $error("watchdog reset while asleep");
  chk_branch_resume: assert property (branch_vector |-> $rose(core_run))
    else $error("branch not at resume");
  chk_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  chk_startup_bound: assert property (ost_cnt_ff <= OST_CYCLES + 2)
    else $error("startup wait too long");
  cov_sleep: cover property (sleep_exec && core_run);
  cov_branch: cover property (branch_vector);
  cov_wdt_reset: cover property (wdt_reset);
endmodule : swc_monitor
bind swc_top swc_monitor #(.OST_CYCLES(OST_CYCLES), .PIN_W(PIN_W)) u_mon (
  .core_clk(core_clk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .sleep_exec(sleep_exec), .pc_now(pc_now),
  .prefetch_addr(prefetch_addr), .core_run(core_run), .branch_vector(branch_vector),
  .vector_addr(vector_addr), .osc_driver_en(osc_driver_en), .pin_out(pin_out),
  .pin_oe(pin_oe), .wdt_reset(wdt_reset));

//--- tb/tb.sv
// self-checking bench for the sleep and wake-up controller
`include "swc_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, go_sleep = 1'b0;
  logic master_clear_pin_n = 1'b1, external_int_pin = 1'b0;
  logic port_change_flag = 1'b0, comparator_flag = 1'b0;
  swc_pkg::swc_addr_t avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic avs_waitrequest, sleep_exec, core_run, core_reset, branch_vector, osc_driver_en;
  logic wdt_reset, wdt_osc_tick;
  logic [12:0] pc_now, prefetch_addr, vector_addr;
  logic [7:0] pin_out_core, pin_oe_core, pin_out, pin_oe;
  int miscompares = 0, checks_done = 0, bv_cnt = 0, rst_cnt = 0, wdtr_cnt = 0;
  swc_top #(.OST_CYCLES(16), .PIN_W(8)) u_dut (
    .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sleep_exec(sleep_exec), .pc_now(pc_now),
    .prefetch_addr(prefetch_addr), .core_run(core_run), .core_reset(core_reset),
    .branch_vector(branch_vector), .vector_addr(vector_addr),
    .master_clear_pin_n(master_clear_pin_n), .external_int_pin(external_int_pin),
    .port_change_flag(port_change_flag), .comparator_flag(comparator_flag),
    .wdt_osc_tick(wdt_osc_tick), .osc_driver_en(osc_driver_en),
    .pin_out_core(pin_out_core), .pin_oe_core(pin_oe_core), .pin_out(pin_out),
    .pin_oe(pin_oe), .wdt_reset(wdt_reset));
  swc_core_model u_core (
    .core_clk(core_clk), .rst(rst), .go_sleep(go_sleep), .core_run(core_run),
    .sleep_exec(sleep_exec), .pc_now(pc_now), .pin_out_core(pin_out_core),
    .pin_oe_core(pin_oe_core), .wdt_osc_tick(wdt_osc_tick));
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (branch_vector === 1'b1) bv_cnt <= bv_cnt + 1;
    if (core_reset === 1'b1) rst_cnt <= rst_cnt + 1;
    if (wdt_reset === 1'b1) wdtr_cnt <= wdtr_cnt + 1;
  end
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic final_report();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic guard(input int n, input int lim);
    if (n >= lim) begin
      miscompares++;
      final_report();
    end
  endtask : guard
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    guard(n, 20);
    @(posedge core_clk);
  endtask : bus
  task automatic do_sleep();
    go_sleep <= 1'b1;
    @(posedge core_clk);
    go_sleep <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : do_sleep
  task automatic wait_wake(output int ost);
    int n;
    n = 0;
    ost = 0;
    while (core_run !== 1'b1 && n < 3000) begin
      @(posedge core_clk);
      n++;
      if (osc_driver_en === 1'b1 && core_run === 1'b0) ost++;
    end
    guard(n, 3000);
    @(posedge core_clk);
  endtask : wait_wake
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic sc_reset_values();
    logic [31:0] q;
    bus(1'b0, `SWC_REG_CTRL, 32'h0, q);
    check(q, `SWC_CTRL_RESET);
    bus(1'b0, `SWC_REG_STATUS, 32'h0, q);
    check(q & 32'h1, 32'h1);
    bus(1'b0, `SWC_REG_IRQ_EN, 32'h0, q);
    check(q, `SWC_IEN_RESET);
    bus(1'b0, `SWC_REG_WDT_LIMIT, 32'h0, q);
    check(q, `SWC_WDT_LIMIT_RESET);
    bus(1'b1, 4'hf, 32'hffff_ffff, q);
    bus(1'b0, 4'hf, 32'h0, q);
    check(q, 32'h0);
  endtask : sc_reset_values
  task automatic sc_irq_wake(input logic [1:0] mode, input logic global_irq_enable);
    logic [31:0] q;
    int ost, bv0;
    bus(1'b1, `SWC_REG_CTRL, {28'h0, mode, global_irq_enable, 1'b0}, q);
    bus(1'b1, `SWC_REG_IRQ_EN, 32'h9, q);
    bv0 = bv_cnt;
    do_sleep();
    bus(1'b0, `SWC_REG_STATUS, 32'h0, q);
    check(q & 32'hf, 32'h6);
    external_int_pin <= 1'b1;
    wait_wake(ost);
    external_int_pin <= 1'b0;
    check(ost >= 16, mode != 2'h0);
    check(bv_cnt - bv0, global_irq_enable);
    bus(1'b0, `SWC_REG_CAUSE, 32'h0, q);
    check(q & 32'h3, 32'h2);
  endtask : sc_irq_wake
  task automatic sc_pending();
    logic [31:0] q;
    int ost;
    bus(1'b1, `SWC_REG_CTRL, 32'h0, q);
    bus(1'b1, `SWC_REG_IRQ_EN, 32'hc, q);
    comparator_flag <= 1'b1;
    repeat (4) @(posedge core_clk);
    do_sleep();
    wait_wake(ost);
    comparator_flag <= 1'b0;
    bus(1'b0, `SWC_REG_CAUSE, 32'h0, q);
    check(q & 32'h3, 32'h2);
  endtask : sc_pending
  task automatic sc_masked_master_clear_pin();
    logic [31:0] q;
    int ost, r0;
    bus(1'b1, `SWC_REG_IRQ_EN, 32'h8, q);
    port_change_flag <= 1'b1;
    do_sleep();
    bus(1'b1, `SWC_REG_IRQ_EN, 32'h1, q);
    external_int_pin <= 1'b1;
    repeat (40) @(posedge core_clk);
    check(core_run, 1'b0);
    r0 = rst_cnt;
    master_clear_pin_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    master_clear_pin_n <= 1'b1;
    wait_wake(ost);
    check(rst_cnt - r0 > 0, 1'b1);
    port_change_flag <= 1'b0;
    external_int_pin <= 1'b0;
  endtask : sc_masked_master_clear_pin
  task automatic sc_wdt_sleep();
    logic [31:0] q;
    int ost, r0, w0;
    bus(1'b1, `SWC_REG_CTRL, 32'h0, q);
    bus(1'b1, `SWC_REG_IRQ_EN, 32'h8, q);
    bus(1'b1, `SWC_REG_WDT_LIMIT, 32'h20, q);
    bus(1'b1, `SWC_REG_CTRL, 32'h1, q);
    r0 = rst_cnt;
    w0 = wdtr_cnt;
    do_sleep();
    wait_wake(ost);
    bus(1'b0, `SWC_REG_STATUS, 32'h0, q);
    check(q & 32'h3, 32'h0);
    bus(1'b0, `SWC_REG_CAUSE, 32'h0, q);
    check(q & 32'h3, 32'h1);
    repeat (30) @(posedge core_clk);
    check(rst_cnt - r0, 0);
    check(wdtr_cnt - w0, 0);
  endtask : sc_wdt_sleep
  task automatic sc_wdt_run();
    int n, w0;
    w0 = wdtr_cnt;
    n = 0;
    while (wdtr_cnt == w0 && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    guard(n, 200);
    check(core_run, 1'b1);
  endtask : sc_wdt_run
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    sc_reset_values();
    for (int m = 0; m < 4; m++) begin
      sc_irq_wake(m[1:0], m[0]);
    end
    sc_pending();
    sc_masked_master_clear_pin();
    sc_wdt_sleep();
    sc_wdt_run();
    final_report();
  end
endmodule : tb
